// ---- common/homing_map.svh ----
`ifndef HOMING_MAP_SVH
`define HOMING_MAP_SVH

// method codes (signed 8-bit)
`define HM_CURRENT       8'sh00
`define HM_SW_OUT_POS    8'sh03
`define HM_SW_OUT_NEG    8'sh05
`define HM_SW_IN_POS     8'sh04
`define HM_SW_IN_NEG     8'sh06
`define HM_LOW_OUT_POS   8'sh07
`define HM_LOW_IN_POS    8'sh08
`define HM_UP_IN_POS     8'sh09
`define HM_UP_OUT_POS    8'sh0A
`define HM_UP_OUT_NEG    8'sh0B
`define HM_UP_IN_NEG     8'sh0C
`define HM_LOW_IN_NEG    8'sh0D
`define HM_LOW_OUT_NEG   8'sh0E
`define HM_UP_POS        8'sh15
`define HM_UP_NEG        8'sh16
`define HM_LOW_POS       8'sh13
`define HM_LOW_NEG       8'sh14
`define HM_SWITCH_POS    8'sh17
`define HM_SWITCH_NEG    8'sh1B
`define HM_CURRENT_ZERO  8'sh23

// home-configuration field positions
`define HC_START_NEG     0
`define HC_USE_INDEX     1
`define HC_INDEX_NEG     2
`define HC_EDGE_RISE     3
`define HC_EDGE_ANY      4
`define HC_MOMENTARY     5
`define HC_FINAL_MOVE    6
`define HC_VALID         7
`define HC_RESET_VALUE   8'h00

`endif

// ---- common/homing_pkg.sv ----
package homing_pkg;
	typedef struct packed {
		logic home;
		logic limPos;
		logic limNeg;
		logic index;
	} sense_t;

	typedef struct packed {
		logic run;
		logic dirNeg;
		logic finalMove;
		logic done;
		logic error;
	} motion_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SEEK   = 3'b001,
		ST_INDEX  = 3'b010,
		ST_FINAL  = 3'b011,
		ST_DONE   = 3'b100,
		ST_ERROR  = 3'b101
	} state_t;
endpackage

// ---- design/homing_sequencer.sv ----
`include "homing_map.svh"
// What this block does
// R1: plain home-switch method homes at switch transition, positive start when switch inactive
// R2: home-switch methods error if any limit activates before the switch transition
// R3: outward index: positive start uses pulse negative side, negative start positive side
// R4: inward index: positive start uses pulse positive side, negative start negative side
// R5: negative-start home-switch variants move negative when switch inactive at start
// R6: lower-home methods use the falling edge of the home switch
// R7: lower-home positive start reverses at positive limit, errors at negative limit after
// R8: lower-home negative start reverses at negative limit, errors at positive limit after
// R9: upper-home methods use the rising edge of the home switch
// R10: motion away from switch reverses at the limit in the start direction
// R11: index-referenced edge methods error on a limit after reversal before the edge
// R12: lower-outside-index homes at first index negative of falling edge
// R13: lower-inside-index homes at first index positive of falling edge
// R14: upper-outside-index homes at first index positive of rising edge
// R15: upper-inside-index homes at first index negative of rising edge
// R16: negative-start upper-outside-index reverses on leaving the home switch
// R17: codes 14, 13 and 12 select the negative-start lower-out, lower-in, upper-in methods
// R18: a standard method code loads the matching home-configuration value
// R19: host may program the home-configuration directly for custom options
// R20: standard methods make a final move to zero, except code 0 which ends at once; custom configuration may suppress it
// R21: host writes the signed 8-bit method code before homing starts
// R22: home latches position and signals done; error stops motion, stays until next start
module homing_sequencer
	import homing_pkg::*;
#(
	parameter int POS_W = 32
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               sys_rst,
	// host settings
	input  wire logic signed [7:0]  methodCode,
	input  wire logic               methodWrite,
	input  wire logic [7:0]         cfgData,
	input  wire logic               cfgWrite,
	input  wire logic               startHoming,
	input  wire logic               finalMoveDone,
	// axis
	input  wire homing_pkg::sense_t pins,
	input  wire logic [POS_W-1:0]   actualPos,
	// results
	output homing_pkg::motion_t     motion,
	output logic [7:0]              homeCfg,
	output logic [POS_W-1:0]        homePos
);
	import homing_pkg::*;

	// map a standard method code to its configuration word
	function automatic logic [7:0] cfgFor(input logic signed [7:0] code);
		logic [7:0] c;
		c = 8'h00;
		c[`HC_VALID] = 1'b1;
		c[`HC_FINAL_MOVE] = 1'b1; // R20
		case (code)
			`HM_CURRENT: begin
				c[`HC_FINAL_MOVE] = 1'b0;
				c[`HC_EDGE_ANY] = 1'b0;
			end
			`HM_CURRENT_ZERO: c[`HC_EDGE_ANY] = 1'b0;
			`HM_SWITCH_POS: c[`HC_EDGE_ANY] = 1'b1; // R1
			`HM_SWITCH_NEG: begin
				c[`HC_EDGE_ANY] = 1'b1;
				c[`HC_START_NEG] = 1'b1; // R5
			end
			`HM_SW_OUT_POS: begin
				c[`HC_EDGE_ANY] = 1'b1;
				c[`HC_USE_INDEX] = 1'b1;
				c[`HC_INDEX_NEG] = 1'b1; // R3
			end
			`HM_SW_OUT_NEG: begin
				c[`HC_EDGE_ANY] = 1'b1;
				c[`HC_USE_INDEX] = 1'b1;
				c[`HC_START_NEG] = 1'b1; // R3
			end
			`HM_SW_IN_POS: begin
				c[`HC_EDGE_ANY] = 1'b1;
				c[`HC_USE_INDEX] = 1'b1; // R4
			end
			`HM_SW_IN_NEG: begin
				c[`HC_EDGE_ANY] = 1'b1;
				c[`HC_USE_INDEX] = 1'b1;
				c[`HC_INDEX_NEG] = 1'b1;
				c[`HC_START_NEG] = 1'b1; // R4
			end
			`HM_LOW_POS: c[`HC_MOMENTARY] = 1'b1; // R6
			`HM_LOW_NEG: begin
				c[`HC_MOMENTARY] = 1'b1;
				c[`HC_START_NEG] = 1'b1;
			end
			`HM_UP_POS: begin
				c[`HC_MOMENTARY] = 1'b1;
				c[`HC_EDGE_RISE] = 1'b1; // R9
			end
			`HM_UP_NEG: begin
				c[`HC_MOMENTARY] = 1'b1;
				c[`HC_EDGE_RISE] = 1'b1;
				c[`HC_START_NEG] = 1'b1;
			end
			`HM_LOW_OUT_POS, `HM_LOW_OUT_NEG: begin
				c[`HC_MOMENTARY] = 1'b1;
				c[`HC_USE_INDEX] = 1'b1;
				c[`HC_INDEX_NEG] = 1'b1; // R12
				c[`HC_START_NEG] = (code == `HM_LOW_OUT_NEG); // R17
			end
			`HM_LOW_IN_POS, `HM_LOW_IN_NEG: begin
				c[`HC_MOMENTARY] = 1'b1;
				c[`HC_USE_INDEX] = 1'b1; // R13
				c[`HC_START_NEG] = (code == `HM_LOW_IN_NEG); // R17
			end
			`HM_UP_OUT_POS, `HM_UP_OUT_NEG: begin
				c[`HC_MOMENTARY] = 1'b1;
				c[`HC_EDGE_RISE] = 1'b1;
				c[`HC_USE_INDEX] = 1'b1; // R14
				c[`HC_START_NEG] = (code == `HM_UP_OUT_NEG);
			end
			`HM_UP_IN_POS, `HM_UP_IN_NEG: begin
				c[`HC_MOMENTARY] = 1'b1;
				c[`HC_EDGE_RISE] = 1'b1;
				c[`HC_USE_INDEX] = 1'b1;
				c[`HC_INDEX_NEG] = 1'b1; // R15
				c[`HC_START_NEG] = (code == `HM_UP_IN_NEG); // R17
			end
			default: c = 8'h00;
		endcase
		return c;
	endfunction

	typedef struct packed {
		state_t           state;
		logic [7:0]       cfg;
		logic             dirNeg;
		logic             reversed;
		logic             edgeSeen;
		logic             homePrev;
		logic             limPosPrev;
		logic             limNegPrev;
		logic [POS_W-1:0] homePos;
		motion_t          motion;
	} seqState_t;

	seqState_t r;
	seqState_t next_r;
	sense_t    s;

	input_sync u_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pinIn   (pins),
		.syncOut (s)
	);

	logic homeRise;
	logic homeFall;
	logic limPosRise;
	logic limNegRise;
	logic refEdge;
	logic leadLim;
	logic trailLim;
	logic momentary;
	logic indexOk;

	always_comb begin
		homeRise   = s.home & ~r.homePrev;
		homeFall   = ~s.home & r.homePrev;
		limPosRise = s.limPos & ~r.limPosPrev;
		limNegRise = s.limNeg & ~r.limNegPrev;
		momentary  = r.cfg[`HC_MOMENTARY];
		// home reference edge
		if (r.cfg[`HC_EDGE_ANY]) begin
			refEdge = homeRise | homeFall; // R1
		end else if (r.cfg[`HC_EDGE_RISE]) begin
			refEdge = homeRise; // R9
		end else begin
			refEdge = homeFall; // R6
		end
		// limit in current direction, and the opposite one
		leadLim  = r.dirNeg ? limNegRise : limPosRise;
		trailLim = r.dirNeg ? limPosRise : limNegRise;
		// index accepted only while moving to the required side of the edge
		indexOk  = s.index & (r.dirNeg == r.cfg[`HC_INDEX_NEG]);
	end

	always_comb begin
		next_r = r;
		next_r.homePrev   = s.home;
		next_r.limPosPrev = s.limPos;
		next_r.limNegPrev = s.limNeg;
		next_r.motion.done = 1'b0;
		if (methodWrite) begin
			next_r.cfg = cfgFor(methodCode); // R18 R21
		end else if (cfgWrite) begin
			next_r.cfg = cfgData | 8'h80;
		end
		case (r.state)
			ST_IDLE, ST_DONE, ST_ERROR: begin
				if (startHoming && r.cfg[`HC_VALID]) begin
					next_r.motion.error = 1'b0; // R22
					next_r.reversed = 1'b0;
					next_r.edgeSeen = 1'b0;
					if (!r.cfg[`HC_EDGE_ANY] && !momentary) begin
						next_r.homePos = actualPos; // current position is home
						next_r.state = r.cfg[`HC_FINAL_MOVE] ? ST_FINAL : ST_DONE;
						next_r.motion.run = r.cfg[`HC_FINAL_MOVE];
						next_r.motion.finalMove = r.cfg[`HC_FINAL_MOVE];
						next_r.motion.done = ~r.cfg[`HC_FINAL_MOVE];
					end else begin
						// R5 R1: start direction when switch inactive; active -> toward edge
						next_r.dirNeg = s.home && r.cfg[`HC_EDGE_ANY]
							? ~r.cfg[`HC_START_NEG] : r.cfg[`HC_START_NEG];
						next_r.state = ST_SEEK;
						next_r.motion.run = 1'b1;
					end
				end
			end
			ST_SEEK: begin
				if (refEdge) begin
					next_r.edgeSeen = 1'b1;
					if (r.cfg[`HC_USE_INDEX]) begin
						next_r.state = ST_INDEX;
						// R3 R4 R12 R13 R14 R15: turn toward the side holding the pulse
						next_r.dirNeg = r.cfg[`HC_INDEX_NEG];
					end else begin
						next_r.homePos = actualPos;
						next_r.state = r.cfg[`HC_FINAL_MOVE] ? ST_FINAL : ST_DONE;
						next_r.motion.finalMove = r.cfg[`HC_FINAL_MOVE]; // R20
						next_r.motion.run = r.cfg[`HC_FINAL_MOVE];
						next_r.motion.done = ~r.cfg[`HC_FINAL_MOVE];
					end
				end else if (momentary && s.home && !r.homePrev && !r.cfg[`HC_EDGE_RISE]
						&& !r.reversed) begin
					next_r.edgeSeen = 1'b0; // approaching the switch, keep going through it
				end else if (momentary && r.cfg[`HC_EDGE_RISE] && homeFall
						&& !r.reversed) begin
					next_r.dirNeg = ~r.dirNeg; // R16
					next_r.reversed = 1'b1;
				end else if (!momentary && (limPosRise || limNegRise)) begin
					next_r.state = ST_ERROR; // R2
					next_r.motion.run = 1'b0;
					next_r.motion.error = 1'b1;
				end else if (momentary && leadLim && !r.reversed) begin
					next_r.dirNeg = ~r.dirNeg; // R7 R8 R10
					next_r.reversed = 1'b1;
				end else if (momentary && (trailLim || leadLim) && r.reversed) begin
					next_r.state = ST_ERROR; // R7 R8 R11
					next_r.motion.run = 1'b0;
					next_r.motion.error = 1'b1;
				end
			end
			ST_INDEX: begin
				if (indexOk) begin
					next_r.homePos = actualPos; // R22
					next_r.state = r.cfg[`HC_FINAL_MOVE] ? ST_FINAL : ST_DONE;
					next_r.motion.finalMove = r.cfg[`HC_FINAL_MOVE];
					next_r.motion.run = r.cfg[`HC_FINAL_MOVE];
					next_r.motion.done = ~r.cfg[`HC_FINAL_MOVE];
				end else if (limPosRise || limNegRise) begin
					next_r.state = ST_ERROR;
					next_r.motion.run = 1'b0;
					next_r.motion.error = 1'b1;
				end
			end
			ST_FINAL: begin
				if (finalMoveDone) begin
					next_r.state = ST_DONE; // R20
					next_r.motion.run = 1'b0;
					next_r.motion.finalMove = 1'b0;
					next_r.motion.done = 1'b1;
				end
			end
			default: next_r.state = ST_IDLE;
		endcase
		// direction output follows the new state, no one-cycle lag
		next_r.motion.dirNeg = next_r.dirNeg;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign motion  = r.motion;
	assign homeCfg = r.cfg;
	assign homePos = r.homePos;

	chk_error_stops: assert property (@(posedge clock) disable iff (sys_rst) // R22
		r.motion.error |-> !r.motion.run)
		else $error("motion runs with error set");
	chk_error_holds: assert property (@(posedge clock) disable iff (sys_rst) // R22
		r.motion.error && !startHoming |=> r.motion.error)
		else $error("error flag dropped before restart");
	chk_cfg_load: assert property (@(posedge clock) disable iff (sys_rst) // R18
		methodWrite && methodCode == `HM_LOW_IN_NEG |=> r.cfg[`HC_START_NEG] && r.cfg[`HC_MOMENTARY])
		else $error("method 13 config wrong");
	chk_limit_error: assert property (@(posedge clock) disable iff (sys_rst) // R2
		r.state == ST_SEEK && !momentary && !refEdge && (limPosRise || limNegRise)
		|=> r.motion.error)
		else $error("limit before switch did not raise error");
	chk_reverse: assert property (@(posedge clock) disable iff (sys_rst) // R10
		r.state == ST_SEEK && momentary && !refEdge && leadLim && !r.reversed
		&& !homeRise && !homeFall |=> r.dirNeg != $past(r.dirNeg))
		else $error("no reversal at leading limit");
	chk_index_home: assert property (@(posedge clock) disable iff (sys_rst) // R12
		r.state == ST_INDEX && indexOk |=> r.homePos == $past(actualPos))
		else $error("home position not latched at index");
	chk_final_move: assert property (@(posedge clock) disable iff (sys_rst) // R20
		r.state == ST_FINAL |-> r.motion.finalMove && r.motion.run)
		else $error("final move not driven");
	chk_done_pulse: assert property (@(posedge clock) disable iff (sys_rst) // R22
		r.motion.done |=> !r.motion.done)
		else $error("done not a single pulse");
	cov_done: cover property (@(posedge clock) r.motion.done);
	cov_error: cover property (@(posedge clock) r.motion.error);
	cov_reverse: cover property (@(posedge clock) !r.reversed ##1 r.reversed);
	cov_index: cover property (@(posedge clock) r.state == ST_INDEX ##1 r.state == ST_FINAL);
endmodule

// ---- design/input_sync.sv ----
module input_sync
	import homing_pkg::*;
(
	// clock and reset
	input  wire logic   clock,
	input  wire logic   sys_rst,
	// pins
	input  wire homing_pkg::sense_t pinIn,
	// synchronised
	output homing_pkg::sense_t syncOut
);
	typedef struct packed {
		sense_t stage1;
		sense_t stage2;
	} syncState_t;

	syncState_t r;
	syncState_t next_r;

	always_comb begin
		next_r.stage1 = pinIn;
		next_r.stage2 = r.stage1;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign syncOut = r.stage2;
endmodule

// ---- verif/axis_model.sv ----
module axis_model
	import homing_pkg::*;
#(
	parameter int STEP = 8,
	parameter int HLO  = 40,
	parameter int HHI  = 50,
	parameter int LP   = 100,
	parameter int LN   = -20,
	parameter int IDX  = 16
) (
	// clock
	input  wire logic                clock,
	// bench control
	input  wire logic                load,
	input  wire logic                homeOn,
	input  wire logic signed [31:0]  startPos,
	// design side
	input  wire homing_pkg::motion_t motion,
	output homing_pkg::sense_t       pins,
	output logic [31:0]              actualPos,
	output logic                     moveDone
);
	timeunit 1ns;
	timeprecision 1ns;

	int pos = 0;
	int stepCnt = 0;
	int moveCnt = 0;

	// slow stepping keeps position steady across the sync delay
	always @(posedge clock) begin
		if (load) begin
			pos <= startPos;
			stepCnt <= 0;
		end else if (motion.run === 1'b1 && motion.finalMove !== 1'b1) begin
			stepCnt <= (stepCnt == STEP - 1) ? 0 : stepCnt + 1;
			if (stepCnt == STEP - 1)
				pos <= (motion.dirNeg === 1'b1) ? pos - 1 : pos + 1;
		end
		moveCnt <= (motion.finalMove === 1'b1) ? moveCnt + 1 : 0;
		moveDone <= (moveCnt == 4);
	end

	always_comb begin
		pins.home   = homeOn && pos >= HLO && pos <= HHI;
		pins.limPos = pos >= LP;
		pins.limNeg = pos <= LN;
		pins.index  = (pos % IDX) == 0;
	end

	assign actualPos = pos;
endmodule

// ---- verif/homing_sequencer_bench.sv ----
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errCount++; \
	$display("Error at %0t: got %0h expected %0h", $time, a, b); end end

module homing_sequencer_bench
	import homing_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic               clock;
	logic               sysRst;
	logic signed [7:0]  methodCode;
	logic               methodWrite;
	logic [7:0]         cfgData;
	logic               cfgWrite;
	logic               startHoming;
	logic               finalMoveDone;
	sense_t             pins;
	logic [31:0]        actualPos;
	motion_t            motion;
	logic [7:0]         homeCfg;
	logic [31:0]        homePos;
	logic               load;
	logic               homeOn;
	logic signed [31:0] startPos;
	logic               prevErr;
	logic               sawFinal;
	logic [32:0]        note;
	logic [32:0]        notes[$];
	int                 errCount;
	int                 numChecks;
	int                 cycles;
	integer             seed;
	// code, start right, switch fitted, negative start, home, error
	int tab [19][6] = '{
		'{'h13, 0, 1, 0, 51, 0}, '{'h13, 1, 1, 0, 39, 0}, '{'h14, 1, 1, 1, 39, 0},
		'{'h14, 0, 1, 1, 51, 0}, '{'h15, 0, 1, 0, 40, 0}, '{'h16, 1, 1, 1, 50, 0},
		'{'h17, 0, 1, 0, 40, 0}, '{'h17, 1, 1, 0, 0, 1}, '{'h13, 0, 0, 0, 0, 1},
		'{'h0E, 0, 0, 1, 0, 1}, '{'h0E, 1, 1, 1, 32, 0}, '{'h0D, 1, 1, 1, 48, 0},
		'{'h0C, 1, 1, 1, 48, 0}, '{'h0A, 0, 1, 0, 48, 0}, '{'h0B, 1, 1, 1, 64, 0},
		'{'h03, 0, 1, 0, 32, 0}, '{'h04, 0, 1, 0, 48, 0}, '{'h06, 1, 1, 1, 48, 0},
		'{'h05, 1, 1, 1, 64, 0}};

	homing_sequencer DUT (
		.clock        (clock),
		.sys_rst      (sysRst),
		.methodCode   (methodCode),
		.methodWrite  (methodWrite),
		.cfgData      (cfgData),
		.cfgWrite     (cfgWrite),
		.startHoming  (startHoming),
		.finalMoveDone(finalMoveDone),
		.pins         (pins),
		.actualPos    (actualPos),
		.motion       (motion),
		.homeCfg      (homeCfg),
		.homePos      (homePos)
	);

	axis_model axis (
		.clock    (clock),
		.load     (load),
		.homeOn   (homeOn),
		.startPos (startPos),
		.motion   (motion),
		.pins     (pins),
		.actualPos(actualPos),
		.moveDone (finalMoveDone)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task final_report();
		$display("checks %0d errors %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errCount++;
			final_report();
		end
	end

	// scoreboard: every done or new error takes the oldest note
	always @(posedge clock) begin
		if (!sysRst && (motion.done === 1'b1 || (motion.error === 1'b1 && prevErr !== 1'b1))) begin
			note = notes.size() ? notes.pop_front() : 33'h1FFFFFFFF;
			`CHK({motion.error, motion.error ? 32'h0 : homePos}, note)
		end
		prevErr <= motion.error;
		if (motion.finalMove === 1'b1)
			sawFinal = 1'b1;
	end

	task run_case(input logic custom, input logic [7:0] sel, input logic right,
		input logic hOn, input logic dir, input int expPos, input logic expErr);
		load <= 1'b1;
		homeOn <= hOn;
		startPos <= (right ? 70 : 10) + 32'($random(seed) & 7);
		@(posedge clock);
		load <= 1'b0;
		if (custom) begin
			cfgData <= sel;
			cfgWrite <= 1'b1;
		end else begin
			methodCode <= sel;
			methodWrite <= 1'b1;
		end
		@(posedge clock);
		cfgWrite <= 1'b0;
		methodWrite <= 1'b0;
		repeat (5) @(posedge clock);
		`CHK(homeCfg[7:6], custom ? {1'b1, sel[6]} : 2'b11)
		sawFinal = 1'b0;
		startHoming <= 1'b1;
		notes.push_back({expErr, expErr ? 32'h0 : 32'(expPos)});
		@(posedge clock);
		startHoming <= 1'b0;
		@(posedge clock);
		`CHK({motion.run, motion.dirNeg}, {1'b1, dir})
		while (motion.done !== 1'b1 && motion.error !== 1'b1)
			@(posedge clock);
		repeat (3) @(posedge clock);
		if (!expErr)
			`CHK(sawFinal, !custom)
	endtask

	initial begin
		seed = 32'hA2406C49;
		sysRst = 1'b1;
		methodCode = 8'sh00;
		methodWrite = 1'b0;
		cfgData = 8'h00;
		cfgWrite = 1'b0;
		startHoming = 1'b0;
		load = 1'b0;
		homeOn = 1'b1;
		startPos = 32'sh0;
		prevErr = 1'b0;
		sawFinal = 1'b0;
		errCount = 0;
		numChecks = 0;
		cycles = 0;
		repeat (12) @(posedge clock);
		sysRst <= 1'b0;
		@(posedge clock);
		// unknown code leaves configuration empty and start refused
		methodCode <= 8'sh7F;
		methodWrite <= 1'b1;
		@(posedge clock);
		methodWrite <= 1'b0;
		@(posedge clock);
		startHoming <= 1'b1;
		@(posedge clock);
		startHoming <= 1'b0;
		repeat (3) @(posedge clock);
		`CHK({homeCfg, motion.run}, 9'h000)
		foreach (tab[i])
			run_case(1'b0, 8'(tab[i][0]), tab[i][1][0], tab[i][2][0], tab[i][3][0],
				tab[i][4], tab[i][5][0]);
		// custom lower-home setup without the final move
		run_case(1'b1, 8'h20, 1'b0, 1'b1, 1'b0, 51, 1'b0);
		final_report();
	end
endmodule
